// file: verilog/gmp_pkg.sv
// Package for the masked GPIO port: register offsets, reset values and codes.
// Assumes a 32-bit AXI4-Lite register bus with 12 decoded byte-address bits.
package gmp_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PINS = 8;

	// Data window: byte addresses 0x000..0x3fc, mask in address bits 9:2
	localparam logic [1:0] WIN_SEL = 2'h0;
	localparam int WIN_HI = 11;
	localparam int WIN_LO = 10;
	localparam int MASK_HI = 9;
	localparam int MASK_LO = 2;

	// Register byte offsets
	localparam logic [11:0] OFS_DIR = 12'h400;
	localparam logic [11:0] OFS_SENSE = 12'h404;
	localparam logic [11:0] OFS_BOTH = 12'h408;
	localparam logic [11:0] OFS_EVENT = 12'h40c;
	localparam logic [11:0] OFS_IMASK = 12'h410;
	localparam logic [11:0] OFS_RAW = 12'h414;
	localparam logic [11:0] OFS_MSTAT = 12'h418;
	localparam logic [11:0] OFS_ICLR = 12'h41c;
	localparam logic [11:0] OFS_PSEL = 12'h420;
	localparam logic [11:0] OFS_DRIVE = 12'h500;
	localparam logic [11:0] OFS_ODRAIN = 12'h50c;
	localparam logic [11:0] OFS_PULLUP = 12'h510;
	localparam logic [11:0] OFS_PULLDN = 12'h514;
	localparam logic [11:0] OFS_SLEW = 12'h518;
	localparam logic [11:0] OFS_LOCK = 12'h520;
	localparam logic [11:0] OFS_COMMIT = 12'h524;
	localparam logic [11:0] OFS_DMAEN = 12'h530;

	// Drive strength codes, two bits per pin
	localparam logic [1:0] DRV_2MA = 2'h0;
	localparam logic [1:0] DRV_4MA = 2'h1;
	localparam logic [1:0] DRV_8MA = 2'h2;
	localparam logic [1:0] DRV_BAD = 2'h3;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_DRIVE = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Lock register read value while locked
	localparam logic [31:0] LOCK_SHOWN = 32'h0000_0001;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verilog/gmp_port.sv
// Masked GPIO port: eight pins, AXI4-Lite registers, pad controls and events.
// Assumes pin_in and the peripheral signals are synchronous to aclk.
`timescale 1ns/1ps

// Function
// - Up to eight pins; present pins set by an instance parameter.
// - Each pin input or output; all pins inputs after reset.
// - Input pins raise events on high, low, rising, falling or both edges.
// - Per-pin drive strength of 2, 4 or 8 mA; resets to 2 mA.
// - Slew limiting takes effect only with 8 mA strength selected.
// - Per-pin weak pull-up or pull-down; neither after reset.
// - Per-pin open-drain option; push-pull after reset.
// - Pin is GPIO or peripheral; GPIO after reset; no-peripheral pins stay GPIO.
// - Multi-pin masks use bit n for pin n; only set bits affected.
// - Masked data read returns selected pins only, others zero.
// - Masked data write updates selected pins together, others unchanged.
// - Data mask comes from the access address; no read-modify-write.
// - Single-pin fields are addressed by pin number 0 to 7.
// - Lockable pins refuse configuration changes until unlocked and committed.
// - Direction is software input, software output or peripheral controlled.
// - Any pin may trigger DMA and still raise its interrupt.
module gmp_port #(
	parameter logic [7:0] PIN_PRESENT = 8'hff,
	parameter logic [7:0] PERIPH_PRESENT = 8'hff,
	parameter logic [7:0] LOCKABLE = 8'h0f,
	parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_c3c3 // arbitrary value
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Package pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// Pad controls
	output logic [15:0] pad_strength,
	output logic [7:0] pad_slew,
	output logic [7:0] pad_pull_up,
	output logic [7:0] pad_pull_down,
	// Peripheral side
	input wire logic [7:0] periph_out,
	input wire logic [7:0] periph_oe,
	output logic [7:0] periph_in,
	// Events
	output logic [7:0] dma_trigger,
	output logic irq
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_hold;
		logic [11:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [7:0] data_out, dir, psel, sense, both, event_hi, imask, edge_lat;
		logic [15:0] drive;
		logic [7:0] slew, odrain, pull_up, pull_dn, dma_en;
		logic unlocked;
		logic [7:0] commit;
		logic primed;
		logic [7:0] pin_prev;
		logic [7:0] pin_out, pin_oe;
		logic [15:0] pad_strength;
		logic [7:0] pad_slew, pad_pu, pad_pd, periph_in, dma_trig;
		logic irq;
	} gmp_state_t;

	gmp_state_t st_reg;
	gmp_state_t st_next;

	// Parameter sanity: some pin present, lockable pins among the present ones
	if (PIN_PRESENT == 8'h00 || (LOCKABLE & ~PIN_PRESENT) != 8'h00)
	begin
		$error("gmp_port: pin parameters unusable");
	end

	// Byte-lane merge of a write into a 32-bit image
	function automatic logic [31:0] gmp_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sb[b])
				res[8*b +: 8] = wd[8*b +: 8];
		end
		return res;
	endfunction

	// Combinational helpers
	logic [7:0] cfg_ok, pin_val, rise, fall, level_hit, edge_hit, raw_stat, hw_ctl, wmask, rmask, wbyte;
	logic [31:0] wword, rword;
	logic rmapped, wmapped, do_write, take_ar;

	always_comb
	begin
		st_next = st_reg;
		// Pins open to configuration: not lockable, or with their commit bit set, unlocked or not
		cfg_ok = PIN_PRESENT & ~(LOCKABLE & ~st_reg.commit);
		hw_ctl = st_reg.psel & PERIPH_PRESENT;
		// Pin value as seen by software: driven value for outputs
		pin_val = PIN_PRESENT & ((st_reg.dir & ~hw_ctl & st_reg.data_out) | (~(st_reg.dir & ~hw_ctl) & pin_in));
		// Event detection on inputs only
		rise = pin_in & ~st_reg.pin_prev & {8{st_reg.primed}};
		fall = ~pin_in & st_reg.pin_prev & {8{st_reg.primed}};
		level_hit = PIN_PRESENT & ~st_reg.dir & st_reg.sense & ~(pin_in ^ st_reg.event_hi);
		edge_hit = PIN_PRESENT & ~st_reg.dir & ~st_reg.sense
			& ((st_reg.both & (rise | fall)) | (~st_reg.both & st_reg.event_hi & rise)
			| (~st_reg.both & ~st_reg.event_hi & fall));
		raw_stat = st_reg.edge_lat | level_hit;

		// Write channel capture, either order
		if (s_axi_awvalid && st_reg.awready)
		begin
			st_next.aw_hold = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready)
		begin
			st_next.w_hold = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;

		// Register write once both halves are held
		do_write = st_reg.aw_hold && st_reg.w_hold;
		wmask = st_reg.aw_addr[gmp_pkg::MASK_HI:gmp_pkg::MASK_LO] & PIN_PRESENT;
		wword = gmp_merge(gmp_pkg::RST_WORD, st_reg.w_data, st_reg.w_strb);
		wbyte = wword[7:0];
		wmapped = 1'b1;
		if (do_write)
		begin
			st_next.aw_hold = 1'b0;
			st_next.w_hold = 1'b0;
			st_next.bvalid = 1'b1;
			if (st_reg.aw_addr[gmp_pkg::WIN_HI:gmp_pkg::WIN_LO] == gmp_pkg::WIN_SEL)
			begin
				if (st_reg.w_strb[0])
					st_next.data_out = (st_reg.data_out & ~wmask) | (st_reg.w_data[7:0] & wmask);
			end
			else
			begin
				unique case (st_reg.aw_addr)
					gmp_pkg::OFS_DIR:
						if (st_reg.w_strb[0])
							st_next.dir = (st_reg.dir & ~cfg_ok) | (wbyte & cfg_ok);
					gmp_pkg::OFS_PSEL:
						if (st_reg.w_strb[0])
							st_next.psel = (st_reg.psel & ~cfg_ok) | (wbyte & cfg_ok & PERIPH_PRESENT);
					gmp_pkg::OFS_SENSE:
						if (st_reg.w_strb[0])
							st_next.sense = wbyte & PIN_PRESENT;
					gmp_pkg::OFS_BOTH:
						if (st_reg.w_strb[0])
							st_next.both = wbyte & PIN_PRESENT;
					gmp_pkg::OFS_EVENT:
						if (st_reg.w_strb[0])
							st_next.event_hi = wbyte & PIN_PRESENT;
					gmp_pkg::OFS_IMASK:
						if (st_reg.w_strb[0])
							st_next.imask = wbyte & PIN_PRESENT;
					gmp_pkg::OFS_ICLR:
						st_next.edge_lat = st_reg.edge_lat & ~wbyte;
					gmp_pkg::OFS_DRIVE:
						for (int p = 0; p < gmp_pkg::PINS; p++)
						begin
							// Unused code 3 keeps the old strength
							if (cfg_ok[p] && st_reg.w_strb[p / 4] && wword[2*p +: 2] != gmp_pkg::DRV_BAD)
								st_next.drive[2*p +: 2] = wword[2*p +: 2];
						end
					gmp_pkg::OFS_SLEW:
						if (st_reg.w_strb[0])
							st_next.slew = (st_reg.slew & ~cfg_ok) | (wbyte & cfg_ok);
					gmp_pkg::OFS_ODRAIN:
						if (st_reg.w_strb[0])
							st_next.odrain = (st_reg.odrain & ~cfg_ok) | (wbyte & cfg_ok);
					gmp_pkg::OFS_PULLUP:
						if (st_reg.w_strb[0])
						begin
							// Setting a pull-up drops the pull-down on that pin
							st_next.pull_up = (st_reg.pull_up & ~cfg_ok) | (wbyte & cfg_ok);
							st_next.pull_dn = st_reg.pull_dn & ~(wbyte & cfg_ok);
						end
					gmp_pkg::OFS_PULLDN:
						if (st_reg.w_strb[0])
						begin
							st_next.pull_dn = (st_reg.pull_dn & ~cfg_ok) | (wbyte & cfg_ok);
							st_next.pull_up = st_reg.pull_up & ~(wbyte & cfg_ok);
						end
					gmp_pkg::OFS_LOCK:
						if (&st_reg.w_strb)
							st_next.unlocked = (st_reg.w_data == UNLOCK_KEY);
					gmp_pkg::OFS_COMMIT:
						if (st_reg.unlocked && st_reg.w_strb[0])
							st_next.commit = wbyte & LOCKABLE;
					gmp_pkg::OFS_DMAEN:
						if (st_reg.w_strb[0])
							st_next.dma_en = wbyte & PIN_PRESENT;
					gmp_pkg::OFS_RAW, gmp_pkg::OFS_MSTAT:
						wmapped = 1'b1;
					default:
						wmapped = 1'b0;
				endcase
			end
			st_next.bresp = wmapped ? gmp_pkg::RESP_OKAY : gmp_pkg::RESP_SLVERR;
		end

		// Edge latch: a new edge wins over a clear in the same cycle
		st_next.edge_lat = (st_next.edge_lat | edge_hit) & PIN_PRESENT;
		st_next.pin_prev = pin_in;
		st_next.primed = 1'b1;

		// Read channel: decode and answer one cycle after the address
		take_ar = s_axi_arvalid && st_reg.arready;
		rmask = s_axi_araddr[gmp_pkg::MASK_HI:gmp_pkg::MASK_LO];
		rword = gmp_pkg::RST_WORD;
		rmapped = 1'b1;
		if (s_axi_araddr[gmp_pkg::WIN_HI:gmp_pkg::WIN_LO] == gmp_pkg::WIN_SEL)
			rword[7:0] = pin_val & rmask;
		else
		begin
			unique case (s_axi_araddr)
				gmp_pkg::OFS_DIR: rword[7:0] = st_reg.dir;
				gmp_pkg::OFS_PSEL: rword[7:0] = st_reg.psel;
				gmp_pkg::OFS_SENSE: rword[7:0] = st_reg.sense;
				gmp_pkg::OFS_BOTH: rword[7:0] = st_reg.both;
				gmp_pkg::OFS_EVENT: rword[7:0] = st_reg.event_hi;
				gmp_pkg::OFS_IMASK: rword[7:0] = st_reg.imask;
				gmp_pkg::OFS_RAW: rword[7:0] = raw_stat;
				gmp_pkg::OFS_MSTAT: rword[7:0] = raw_stat & st_reg.imask;
				gmp_pkg::OFS_DRIVE: rword[15:0] = st_reg.drive;
				gmp_pkg::OFS_SLEW: rword[7:0] = st_reg.slew;
				gmp_pkg::OFS_ODRAIN: rword[7:0] = st_reg.odrain;
				gmp_pkg::OFS_PULLUP: rword[7:0] = st_reg.pull_up;
				gmp_pkg::OFS_PULLDN: rword[7:0] = st_reg.pull_dn;
				gmp_pkg::OFS_LOCK: rword = st_reg.unlocked ? gmp_pkg::RST_WORD : gmp_pkg::LOCK_SHOWN;
				gmp_pkg::OFS_COMMIT: rword[7:0] = st_reg.commit;
				gmp_pkg::OFS_DMAEN: rword[7:0] = st_reg.dma_en;
				gmp_pkg::OFS_ICLR: rword = gmp_pkg::RST_WORD;
				default: rmapped = 1'b0;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (take_ar)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rword;
			st_next.rresp = rmapped ? gmp_pkg::RESP_OKAY : gmp_pkg::RESP_SLVERR;
		end

		// Ready flags: one write and one read outstanding at most
		st_next.awready = ~st_next.aw_hold & ~st_next.bvalid;
		st_next.wready = ~st_next.w_hold & ~st_next.bvalid;
		st_next.arready = ~st_next.rvalid;

		// Pad and pin drive, per pin
		for (int p = 0; p < gmp_pkg::PINS; p++)
		begin
			logic drv;
			logic val;
			drv = 1'b0;
			val = 1'b0;
			if (PIN_PRESENT[p])
			begin
				if (hw_ctl[p])
				begin
					drv = periph_oe[p];
					val = periph_out[p];
				end
				else
				begin
					drv = st_reg.dir[p];
					val = st_reg.data_out[p];
				end
			end
			// Open drain only pulls low
			st_next.pin_oe[p] = st_reg.odrain[p] ? (drv & ~val) : drv;
			st_next.pin_out[p] = st_reg.odrain[p] ? 1'b0 : val;
			st_next.pad_slew[p] = st_reg.slew[p] & (st_reg.drive[2*p +: 2] == gmp_pkg::DRV_8MA);
		end
		st_next.pad_strength = st_reg.drive;
		st_next.pad_pu = st_reg.pull_up & PIN_PRESENT;
		st_next.pad_pd = st_reg.pull_dn & PIN_PRESENT;
		st_next.periph_in = pin_in & hw_ctl;
		// DMA trigger alongside the interrupt, not instead of it
		st_next.dma_trig = (edge_hit | level_hit) & st_reg.dma_en;
		st_next.irq = |(raw_stat & st_reg.imask);
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0;
			st_reg.dir <= gmp_pkg::RST_BYTE;
			st_reg.psel <= gmp_pkg::RST_BYTE;
			st_reg.drive <= gmp_pkg::RST_DRIVE;
			st_reg.odrain <= gmp_pkg::RST_BYTE;
			st_reg.pull_up <= gmp_pkg::RST_BYTE;
			st_reg.pull_dn <= gmp_pkg::RST_BYTE;
			st_reg.bresp <= gmp_pkg::RESP_OKAY;
			st_reg.rresp <= gmp_pkg::RESP_OKAY;
		end
		else
			st_reg <= st_next;
	end

	// Outputs straight from the state register
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign pin_out = st_reg.pin_out;
	assign pin_oe = st_reg.pin_oe;
	assign pad_strength = st_reg.pad_strength;
	assign pad_slew = st_reg.pad_slew;
	assign pad_pull_up = st_reg.pad_pu;
	assign pad_pull_down = st_reg.pad_pd;
	assign periph_in = st_reg.periph_in;
	assign dma_trigger = st_reg.dma_trig;
	assign irq = st_reg.irq;

endmodule

// file: verif/gmp_pin_model.sv
// Pin-side partner: resolves each package pin seen by the port.
// Assumes one clock; the resolved level is registered on aclk.
`timescale 1ns/1ps
module gmp_pin_model (
	// Clock
	input wire logic aclk,
	// Port drive and pulls
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pull_up,
	input wire logic [7:0] pull_down,
	// External driver
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// Level seen by the port
	output logic [7:0] pin_in = 8'h00
);
	// Port drive wins, then the outside driver, then a pull; a floating pin flips
	always @(posedge aclk)
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pin_oe[i])
				pin_in[i] <= pin_out[i];
			else if (ext_en[i])
				pin_in[i] <= ext_val[i];
			else if (pull_up[i] || pull_down[i])
				pin_in[i] <= pull_up[i];
			else
				pin_in[i] <= ~pin_in[i];
		end
	end
endmodule

// file: verif/gmp_port_monitor.sv
// Checker for the masked GPIO port: bus handshakes, pad codes and reset.
// Assumes it is bound to gmp_port and sees its ports only.
`timescale 1ns/1ps
module gmp_port_monitor (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pad side
	input wire logic [7:0] pin_oe,
	input wire logic [15:0] pad_strength,
	input wire logic [7:0] pad_slew,
	input wire logic [7:0] pad_pull_up,
	input wire logic [7:0] pad_pull_down
);
	logic [7:0] fast;
	logic [7:0] bad;

	default clocking cb @(posedge aclk);
	endclocking

	// Per-pin decode of the strength code
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			fast[i] = pad_strength[2*i+:2] == gmp_pkg::DRV_8MA;
			bad[i] = pad_strength[2*i+:2] == gmp_pkg::DRV_BAD;
		end
	end

	AST_RESET_QUIET: assert property (!aresetn |=> pin_oe == 8'h00 && pad_pull_up == 8'h00)
		else $error("outputs not cleared by reset");
	AST_PULL_EXCL: assert property (disable iff (!aresetn) (pad_pull_up & pad_pull_down) == 8'h00)
		else $error("pull-up and pull-down both on");
	AST_SLEW_8MA: assert property (disable iff (!aresetn) (pad_slew & ~fast) == 8'h00)
		else $error("slew limit without strongest drive");
	AST_NO_BAD_DRIVE: assert property (disable iff (!aresetn) bad == 8'h00)
		else $error("illegal strength code");
	AST_WR_RESP: assert property (disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_TIME: assert property (disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_R_ERR_ZERO: assert property (disable iff (!aresetn)
		s_axi_rvalid && s_axi_rresp == gmp_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
		else $error("error read with data");
endmodule

bind gmp_port gmp_port_monitor MON (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pin_oe(pin_oe), .pad_strength(pad_strength), .pad_slew(pad_slew), .pad_pull_up(pad_pull_up),
	.pad_pull_down(pad_pull_down));

// file: verif/gmp_port_tb.sv
// Testbench for the masked GPIO port: lock, masked data, pads, events, bus errors.
// Assumes gmp_port, the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module gmp_port_tb;
	localparam logic [31:0] KEY = 32'h1234_abcd; // arbitrary value
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0, irq;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pin_in, pin_out, pin_oe, pad_slew, pad_pull_up, pad_pull_down, periph_in, dma_trigger;
	logic [7:0] periph_out = 0, periph_oe = 0, ext_en = 0, ext_val = 0;
	logic [15:0] pad_strength;
	int mismatches = 0, tests_run = 0;

	// Clock
	always #10 aclk = ~aclk;

	gmp_port #(.UNLOCK_KEY(KEY)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pad_strength(pad_strength), .pad_slew(pad_slew), .pad_pull_up(pad_pull_up),
		.pad_pull_down(pad_pull_down), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .dma_trigger(dma_trigger), .irq(irq));
	gmp_pin_model PINS (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pad_pull_up),
		.pull_down(pad_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// A non-zero lag holds bready low until that many edges have passed
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0, input int lag = 0);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= (lag == 0);
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 0;
			if (n >= lag && !s_axi_bready)
				s_axi_bready <= 1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
		s_axi_bready <= 0;
		if (n >= 40)
		begin
			mismatches++;
			end_sim();
		end
		chk("bresp", s_axi_bresp, er);
		@(posedge aclk);
	endtask

	// A non-zero lag holds rready low until that many edges have passed
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0, input int lag = 0);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= (lag == 0);
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 0;
			if (n >= lag && !s_axi_rready)
				s_axi_rready <= 1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
		s_axi_rready <= 0;
		if (n >= 40)
		begin
			mismatches++;
			end_sim();
		end
		chk("rresp", s_axi_rresp, er);
		chk("rdata", s_axi_rdata, e);
		@(posedge aclk);
	endtask

	// Reset values of pads and configuration
	task automatic t_reset();
		chk("oe", pin_oe, 0);
		chk("pulls", {pad_pull_up, pad_pull_down}, 0);
		rd(gmp_pkg::OFS_DIR, 0);
		rd(gmp_pkg::OFS_PSEL, 0);
		rd(gmp_pkg::OFS_DRIVE, 0);
		rd(gmp_pkg::OFS_ODRAIN, 0);
		rd(gmp_pkg::OFS_PULLUP, 0);
		rd(gmp_pkg::OFS_LOCK, gmp_pkg::LOCK_SHOWN);
	endtask

	// Locked pins refuse changes until unlocked and committed
	task automatic t_lock();
		wr(gmp_pkg::OFS_DIR, 32'hff);
		rd(gmp_pkg::OFS_DIR, 32'hf0);
		wr(gmp_pkg::OFS_COMMIT, 32'h0f);
		rd(gmp_pkg::OFS_COMMIT, 0);
		wr(gmp_pkg::OFS_LOCK, KEY, gmp_pkg::RESP_OKAY, 3);
		rd(gmp_pkg::OFS_LOCK, 0, gmp_pkg::RESP_OKAY, 3);
		wr(gmp_pkg::OFS_COMMIT, 32'h0f);
		wr(gmp_pkg::OFS_DIR, 32'hff);
		rd(gmp_pkg::OFS_DIR, 32'hff);
	endtask

	// Address-masked writes and reads
	task automatic t_data();
		wr(12'h024, 32'hff);
		chk("oe", pin_oe, 8'hff);
		chk("out", pin_out, 8'h09);
		wr(12'h3c0, 32'ha5);
		chk("out", pin_out, 8'ha9);
		rd(12'h03c, 32'h09);
		rd(12'h3fc, 32'ha9);
	endtask

	// Strength, slew, pulls, open drain and peripheral hand-over
	task automatic t_pad();
		wr(gmp_pkg::OFS_DRIVE, 32'h06);
		wr(gmp_pkg::OFS_SLEW, 32'h03);
		chk("slew", pad_slew, 8'h01);
		wr(gmp_pkg::OFS_DRIVE, 32'h36);
		chk("strength", pad_strength, 16'h0006);
		wr(gmp_pkg::OFS_PULLUP, 32'h0f);
		wr(gmp_pkg::OFS_PULLDN, 32'h03);
		chk("pulls", {pad_pull_up, pad_pull_down}, 16'h0c03);
		wr(gmp_pkg::OFS_ODRAIN, 32'h80);
		chk("oe", pin_oe, 8'h7f);
		periph_oe <= 8'h01;
		wr(gmp_pkg::OFS_PSEL, 32'h01);
		chk("out", pin_out, 8'h28);
		periph_oe <= 0;
		ext_en <= 8'h01;
		ext_val <= 8'h01;
		repeat (4) @(posedge aclk);
		chk("periph_in", periph_in, 8'h01);
		wr(gmp_pkg::OFS_PSEL, 0);
	endtask

	// Every event kind, masking, clearing and the DMA trigger
	task automatic t_event();
		ext_en <= 8'hff;
		ext_val <= 8'h88;
		wr(gmp_pkg::OFS_DIR, 0);
		wr(gmp_pkg::OFS_SENSE, 32'ha0);
		wr(gmp_pkg::OFS_EVENT, 32'h30);
		wr(gmp_pkg::OFS_BOTH, 32'h40);
		wr(gmp_pkg::OFS_ICLR, 32'hff);
		rd(gmp_pkg::OFS_RAW, 0);
		wr(gmp_pkg::OFS_IMASK, 32'h10);
		wr(gmp_pkg::OFS_DMAEN, 32'h20);
		ext_val <= 8'h70;
		repeat (5) @(posedge aclk);
		rd(gmp_pkg::OFS_RAW, 32'hf8);
		rd(gmp_pkg::OFS_MSTAT, 32'h10);
		chk("irq", irq, 1);
		chk("dma", dma_trigger, 8'h20);
		wr(gmp_pkg::OFS_ICLR, 32'h18);
		rd(gmp_pkg::OFS_RAW, 32'he0);
		chk("irq", irq, 0);
		rd(12'h600, 0, gmp_pkg::RESP_SLVERR);
		wr(12'h600, 32'hff, gmp_pkg::RESP_SLVERR);
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset();
		t_lock();
		t_data();
		t_pad();
		t_event();
		end_sim();
	end
endmodule
